// ==== hw/pfc_cfg.svh ====
// constants for the program flow control block
// Functional notes
// - fetch cycle one: second into top, memory word at old top into second
// - fetch cycle two: fetched word into top, old second back into second
// - bit 15 clear means call; one cycle, parameter stack untouched
// - call pushes index page and loop index, loads pc from address field
// - call byte address is word field shifted left with zero lsb
// - call saves index page and loop index; pc and code page move in
// - non-call, non-branch instruction with bit 5 also returns
// - return: pc from loop index, code page from index page, then pop
// - return costs one cycle alone, none when merged
// - bit 5 of branches and calls is address, never a return
// - return-stack pop with return bit reads index without popping, no return
// - pc bits 15-10 are block number, bits 9-0 word offset
// - branch targets same, next, previous block or block zero
// - offset field replaces pc bits 9-1, pc bit 0 forced zero
// - block select applies to the incremented pc
// - block select 00 keeps block, 01 takes next block
// - unconditional branch loads address in one cycle, stacks unchanged
// - popping zero branch always pops, branches only when top is zero
// - non-popping zero branch pops and branches on zero, else nothing
// - loop branch decrements index and branches when index non-zero
// - loop branch with zero index pops return stack and falls through
// - class 8 or 9 in bits 15-12 is the branch and loop group
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define PFC_CALL_BIT 15
`define PFC_RET_BIT 5
`define PFC_GRP_HI 15
`define PFC_GRP_LO 13
`define PFC_GRP_BRANCH 3'h4
`define PFC_CLASS_HI 15
`define PFC_CLASS_LO 12
`define PFC_CLASS_FETCH 4'he
`define PFC_COND_HI 12
`define PFC_COND_LO 11
`define PFC_BLK_HI 10
`define PFC_BLK_LO 9
`define PFC_OFS_HI 8
`define PFC_OFS_LO 0
// return-stack pop instruction: class 11 with bits 11-8 matching
`define PFC_RPOP_MASK 16'hff00
`define PFC_RPOP_MATCH 16'hb700

// ----------------------------------------
// pc layout and step
// ----------------------------------------
`define PFC_PC_BLK_HI 15
`define PFC_PC_BLK_LO 10
`define PFC_PC_STEP 16'h0002

// ----------------------------------------
// reset values
// ----------------------------------------
`define PFC_RST_PC 16'h0000
`define PFC_RST_WORD 16'h0000

`endif

// ==== hw/pfc_pkg.sv ====
// types for the program flow control block
package pfc_pkg;

	typedef enum logic [2:0] {
		PFC_EXEC = 3'b001,
		PFC_FETCH1 = 3'b010,
		PFC_FETCH2 = 3'b100
	} pfc_state_e;

	typedef enum logic [1:0] {
		PFC_CC_ZERO_POP = 2'b00,
		PFC_CC_ZERO_KEEP = 2'b01,
		PFC_CC_ALWAYS = 2'b10,
		PFC_CC_LOOP = 2'b11
	} pfc_cond_e;

	typedef enum logic [1:0] {
		PFC_BLK_SAME = 2'b00,
		PFC_BLK_NEXT = 2'b01,
		PFC_BLK_PREV = 2'b10,
		PFC_BLK_ZERO = 2'b11
	} pfc_blk_e;

	typedef logic [15:0] pfc_word_t;

endpackage

// ==== hw/pfc_core.sv ====
// program flow control: call, return, branch, loop and fetch sequencing
`timescale 1ns/1ps
`include "pfc_cfg.svh"

module pfc_core #(
	parameter int CODE_PAGE_W = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// instruction memory
	input wire pfc_pkg::pfc_word_t instr,
	input wire logic instr_valid,
	output logic instr_ready,
	output pfc_pkg::pfc_word_t pc,
	// code page load by a preceding instruction
	input wire logic code_page_wr,
	input wire logic [CODE_PAGE_W-1:0] code_page_wdata,
	output logic [CODE_PAGE_W-1:0] code_page_reg,
	// data memory read
	output logic mem_rd,
	output pfc_pkg::pfc_word_t mem_addr,
	input wire pfc_pkg::pfc_word_t mem_rdata,
	// return stack controller
	output logic rs_push,
	output logic [CODE_PAGE_W-1:0] rs_push_page,
	output pfc_pkg::pfc_word_t rs_push_index,
	output logic rs_pop,
	input wire logic [CODE_PAGE_W-1:0] rs_pop_page,
	input wire pfc_pkg::pfc_word_t rs_pop_index,
	// parameter stack controller
	output logic ps_push,
	output pfc_pkg::pfc_word_t ps_push_data,
	output logic ps_pop,
	input wire pfc_pkg::pfc_word_t ps_top,
	// working registers
	output pfc_pkg::pfc_word_t top,
	output pfc_pkg::pfc_word_t second,
	output pfc_pkg::pfc_word_t loop_index,
	output logic [CODE_PAGE_W-1:0] index_page_reg
);
	import pfc_pkg::*;

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (CODE_PAGE_W < 1 || CODE_PAGE_W > 16) begin : g_bad_width
		$error("CODE_PAGE_W must lie between 1 and 16");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		pfc_state_e state;
		logic ready;
		pfc_word_t pc;
		logic [CODE_PAGE_W-1:0] code_page;
		logic [CODE_PAGE_W-1:0] index_page;
		pfc_word_t index;
		pfc_word_t top;
		pfc_word_t second;
		logic mem_rd;
		pfc_word_t mem_addr;
		logic rs_push;
		logic [CODE_PAGE_W-1:0] rs_push_page;
		pfc_word_t rs_push_index;
		logic rs_pop;
		logic ps_push;
		pfc_word_t ps_push_data;
		logic ps_pop;
	} pfc_st_s;

	pfc_st_s st;
	pfc_st_s next_st;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic is_call(input pfc_word_t op);
		return !op[`PFC_CALL_BIT];
	endfunction

	function automatic logic is_branch(input pfc_word_t op);
		// classes 8 and 9 share the top three bits
		return op[`PFC_GRP_HI:`PFC_GRP_LO] == `PFC_GRP_BRANCH;
	endfunction

	function automatic logic is_rpop(input pfc_word_t op);
		return (op & `PFC_RPOP_MASK) == `PFC_RPOP_MATCH;
	endfunction

	// target built from the already incremented pc
	function automatic pfc_word_t branch_adr(input pfc_word_t pc_inc, input pfc_word_t op);
		logic [5:0] blk;
		logic [5:0] new_blk;
		pfc_blk_e sel;
		blk = pc_inc[`PFC_PC_BLK_HI:`PFC_PC_BLK_LO];
		sel = pfc_blk_e'(op[`PFC_BLK_HI:`PFC_BLK_LO]);
		case (sel)
			PFC_BLK_SAME: new_blk = blk;
			PFC_BLK_NEXT: new_blk = blk + 6'h01;
			PFC_BLK_PREV: new_blk = blk - 6'h01;
			PFC_BLK_ZERO: new_blk = 6'h00;
			default: new_blk = blk;
		endcase
		return {new_blk, op[`PFC_OFS_HI:`PFC_OFS_LO], 1'b0};
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		pfc_word_t pc_inc;
		pfc_word_t adr;
		pfc_cond_e cond;
		logic ret_req;
		pc_inc = st.pc + `PFC_PC_STEP;
		adr = branch_adr(pc_inc, instr);
		cond = pfc_cond_e'(instr[`PFC_COND_HI:`PFC_COND_LO]);
		ret_req = 1'b0;
		next_st = st;
		// strobes last one cycle
		next_st.mem_rd = 1'b0;
		next_st.rs_push = 1'b0;
		next_st.rs_pop = 1'b0;
		next_st.ps_push = 1'b0;
		next_st.ps_pop = 1'b0;
		case (st.state)
			PFC_EXEC: begin
				if (instr_valid) begin
					next_st.pc = pc_inc;
					if (code_page_wr) begin
						next_st.code_page = code_page_wdata;
					end
					if (is_call(instr)) begin
						// saved pair goes out, pc and page move in
						next_st.rs_push = 1'b1;
						next_st.rs_push_page = st.index_page;
						next_st.rs_push_index = st.index;
						next_st.index = pc_inc;
						next_st.index_page = st.code_page;
						next_st.pc = {instr[14:0], 1'b0};
					end else if (is_branch(instr)) begin
						// bit 5 is part of the offset here
						case (cond)
							PFC_CC_ALWAYS: begin
								next_st.pc = adr;
							end
							PFC_CC_ZERO_POP: begin
								next_st.top = st.second;
								next_st.second = ps_top;
								next_st.ps_pop = 1'b1;
								if (st.top == `PFC_RST_WORD) begin
									next_st.pc = adr;
								end
							end
							PFC_CC_ZERO_KEEP: begin
								if (st.top == `PFC_RST_WORD) begin
									next_st.top = st.second;
									next_st.second = ps_top;
									next_st.ps_pop = 1'b1;
									next_st.pc = adr;
								end
							end
							PFC_CC_LOOP: begin
								if (st.index != `PFC_RST_WORD) begin
									next_st.index = st.index - 16'h0001;
									next_st.pc = adr;
								end else begin
									next_st.index = rs_pop_index;
									next_st.index_page = rs_pop_page;
									next_st.rs_pop = 1'b1;
								end
							end
							default: begin
								next_st.pc = pc_inc;
							end
						endcase
					end else begin
						if (instr[`PFC_CLASS_HI:`PFC_CLASS_LO] == `PFC_CLASS_FETCH) begin
							next_st.mem_rd = 1'b1;
							next_st.mem_addr = st.top;
							next_st.state = PFC_FETCH1;
						end
						if (is_rpop(instr)) begin
							// old second goes onto the parameter stack
							next_st.top = st.index;
							next_st.second = st.top;
							next_st.ps_push = 1'b1;
							next_st.ps_push_data = st.second;
							if (!instr[`PFC_RET_BIT]) begin
								next_st.index = rs_pop_index;
								next_st.index_page = rs_pop_page;
								next_st.rs_pop = 1'b1;
							end
							// return bit set: plain index read, no return
						end else begin
							ret_req = instr[`PFC_RET_BIT];
						end
						if (ret_req) begin
							// merged into the instruction, no extra cycle
							next_st.pc = st.index;
							next_st.code_page = st.index_page;
							next_st.index = rs_pop_index;
							next_st.index_page = rs_pop_page;
							next_st.rs_pop = 1'b1;
						end
					end
				end
			end
			PFC_FETCH1: begin
				next_st.top = st.second;
				next_st.second = mem_rdata;
				next_st.state = PFC_FETCH2;
			end
			PFC_FETCH2: begin
				next_st.top = st.second;
				next_st.second = st.top;
				next_st.state = PFC_EXEC;
			end
			default: begin
				next_st.state = PFC_EXEC;
			end
		endcase
		next_st.ready = (next_st.state == PFC_EXEC);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st.state <= PFC_EXEC;
			st.ready <= 1'b1;
			st.pc <= `PFC_RST_PC;
			st.code_page <= '0;
			st.index_page <= '0;
			st.index <= `PFC_RST_WORD;
			st.top <= `PFC_RST_WORD;
			st.second <= `PFC_RST_WORD;
			st.mem_rd <= 1'b0;
			st.mem_addr <= `PFC_RST_WORD;
			st.rs_push <= 1'b0;
			st.rs_push_page <= '0;
			st.rs_push_index <= `PFC_RST_WORD;
			st.rs_pop <= 1'b0;
			st.ps_push <= 1'b0;
			st.ps_push_data <= `PFC_RST_WORD;
			st.ps_pop <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign instr_ready = st.ready;
	assign pc = st.pc;
	assign code_page_reg = st.code_page;
	assign mem_rd = st.mem_rd;
	assign mem_addr = st.mem_addr;
	assign rs_push = st.rs_push;
	assign rs_push_page = st.rs_push_page;
	assign rs_push_index = st.rs_push_index;
	assign rs_pop = st.rs_pop;
	assign ps_push = st.ps_push;
	assign ps_push_data = st.ps_push_data;
	assign ps_pop = st.ps_pop;
	assign top = st.top;
	assign second = st.second;
	assign loop_index = st.index;
	assign index_page_reg = st.index_page;

endmodule

// ==== tb/pfc_core_chk.sv ====
// assertions watching the program flow control ports
`timescale 1ns/1ps
module pfc_core_chk #(
	parameter int CODE_PAGE_W = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// instruction side
	input wire pfc_pkg::pfc_word_t instr,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire pfc_pkg::pfc_word_t pc,
	input wire logic [CODE_PAGE_W-1:0] code_page_reg,
	// memory and stacks
	input wire logic mem_rd,
	input wire pfc_pkg::pfc_word_t mem_addr,
	input wire logic rs_push,
	input wire logic rs_pop,
	input wire pfc_pkg::pfc_word_t rs_pop_index,
	input wire logic ps_pop,
	// working registers
	input wire pfc_pkg::pfc_word_t top,
	input wire pfc_pkg::pfc_word_t second,
	input wire pfc_pkg::pfc_word_t loop_index,
	input wire logic [CODE_PAGE_W-1:0] index_page_reg
);
	import pfc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic go, br;
	pfc_word_t pc_nx;
	logic [5:0] tblk;
	assign go = instr_ready && instr_valid;
	assign br = go && instr[15:13] == 3'h4;
	// block select works on the address after the branch, not its own
	assign pc_nx = pc + 16'h0002;
	always_comb begin
		case (instr[10:9])
			2'b00: tblk = pc_nx[15:10];
			2'b01: tblk = pc_nx[15:10] + 6'h01;
			2'b10: tblk = pc_nx[15:10] - 6'h01;
			default: tblk = 6'h00;
		endcase
	end
	a_call_target: assert property (go && !instr[15] |=> pc == {$past(instr[14:0]), 1'b0}
		&& rs_push && !ps_pop) else $error("call target or push wrong");
	a_call_save: assert property (go && !instr[15] |=> loop_index == $past(pc_nx)
		&& index_page_reg == $past(code_page_reg)) else $error("call save wrong");
	a_ret_load: assert property (go && instr[15:13] != 3'h4 && instr[15] && instr[5]
		&& (instr & 16'hff00) != 16'hb700 |=> pc == $past(loop_index) && rs_pop
		&& code_page_reg == $past(index_page_reg)) else $error("return wrong");
	a_rpop_keep: assert property (go && (instr & 16'hff20) == 16'hb720 |=> !rs_pop
		&& pc == $past(pc_nx) && top == $past(loop_index)) else $error("rpop with return bit");
	a_br_target: assert property (br && instr[12:11] == 2'b10 |=> pc[9:0] == {$past(instr[8:0]),
		1'b0} && top == $past(top) && !ps_pop && !rs_push) else $error("branch wrong");
	a_blk_select: assert property (br && instr[12:11] == 2'b10
		|=> pc[15:10] == $past(tblk)) else $error("block select wrong");
	a_zero_pop: assert property (br && instr[12:11] == 2'b00 |=> ps_pop
		&& top == $past(second)) else $error("zero pop branch wrong");
	a_zero_keep: assert property (br && instr[12:11] == 2'b01 && top != 16'h0000
		|=> !ps_pop && pc == $past(pc_nx) && top == $past(top)) else $error("keep branch acted");
	a_loop_dec: assert property (br && instr[12:11] == 2'b11 && loop_index != 16'h0000
		|=> loop_index == $past(loop_index) - 16'h0001) else $error("loop decrement wrong");
	a_loop_end: assert property (br && instr[12:11] == 2'b11 && loop_index == 16'h0000
		|=> rs_pop && pc == $past(pc_nx) && loop_index == $past(rs_pop_index))
		else $error("loop exit wrong");
	a_fetch_seq: assert property (go && instr[15:12] == 4'he |=> mem_rd
		&& mem_addr == $past(top) && !instr_ready ##1 !instr_ready && top == $past(second, 2)
		##1 instr_ready && top == $past(second) && second == $past(top))
		else $error("fetch sequence wrong");
	c_call: cover property (go && !instr[15]);
	c_loop_end: cover property (br && instr[12:11] == 2'b11 && loop_index == 16'h0000);
	c_fetch: cover property (go && instr[15:12] == 4'he);
endmodule
bind pfc_core pfc_core_chk #(.CODE_PAGE_W(CODE_PAGE_W)) u_chk (.*);

// ==== tb/pfc_far.sv ====
// behavioural memory and stack controllers facing the flow block
`timescale 1ns/1ps
module pfc_far (
	input wire logic core_clk,
	input wire logic mem_rd,
	input wire pfc_pkg::pfc_word_t mem_addr,
	output pfc_pkg::pfc_word_t mem_rdata,
	input wire logic rs_push,
	input wire logic [3:0] rs_push_page,
	input wire pfc_pkg::pfc_word_t rs_push_index,
	input wire logic rs_pop,
	output logic [3:0] rs_pop_page,
	output pfc_pkg::pfc_word_t rs_pop_index,
	input wire logic ps_push,
	input wire pfc_pkg::pfc_word_t ps_push_data,
	input wire logic ps_pop,
	output pfc_pkg::pfc_word_t ps_top
);
	import pfc_pkg::*;
	pfc_word_t rsi [16];
	logic [3:0] rsp [16];
	pfc_word_t psd [16];
	logic [3:0] rp, pp;
	pfc_word_t cyc;
	initial begin
		rp = 4'h0;
		pp = 4'h0;
		cyc = 16'h0000;
		for (int k = 0; k < 16; k++) begin
			rsi[k] = 16'h0100 + 16'(k);
			rsp[k] = 4'(k);
			psd[k] = 16'h0a00 + 16'(k);
		end
	end
	// idle bus wanders so a stale word is never taken for a read
	assign mem_rdata = mem_rd ? (mem_addr ^ 16'h5a5a) : cyc;
	assign rs_pop_index = rsi[rp];
	assign rs_pop_page = rsp[rp];
	assign ps_top = psd[pp];
	always @(posedge core_clk) begin
		cyc <= cyc + 16'h0001;
		if (rs_push) begin
			rsi[rp + 4'h1] <= rs_push_index;
			rsp[rp + 4'h1] <= rs_push_page;
			rp <= rp + 4'h1;
		end else if (rs_pop) begin
			rp <= rp - 4'h1;
		end
		if (ps_push) begin
			psd[pp + 4'h1] <= ps_push_data;
			pp <= pp + 4'h1;
		end else if (ps_pop) begin
			pp <= pp - 4'h1;
		end
	end
endmodule

// ==== tb/tb.sv ====
// self-checking testbench for the program flow control block
`timescale 1ns/1ps
module tb;
	import pfc_pkg::*;
	logic core_clk, rst_b, instr_valid, instr_ready, code_page_wr, mem_rd;
	logic rs_push, rs_pop, ps_push, ps_pop;
	logic [3:0] code_page_wdata, code_page_reg, rs_push_page, rs_pop_page, index_page_reg;
	pfc_word_t instr, pc, mem_addr, mem_rdata, rs_push_index, rs_pop_index;
	pfc_word_t ps_push_data, ps_top, top, second, loop_index;
	int miscompares, comparisons;
	pfc_core DUT (.*);
	pfc_far FAR (.*);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task complete_run;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input pfc_word_t e, input pfc_word_t g);
		comparisons++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	// wait for ready, issue one instruction, return just after its edge
	task exec(input pfc_word_t i, input logic [3:0] w = 4'h0);
		int n;
		n = 0;
		while (instr_ready !== 1'b1) begin
			n++;
			if (n > 10) begin
				miscompares++;
				complete_run();
			end
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		instr <= i;
		instr_valid <= 1'b1;
		code_page_wr <= (w != 4'h0);
		code_page_wdata <= w;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		code_page_wr <= 1'b0;
		#1;
	endtask
	// top and second start at zero straight after reset
	task t_zero;
		pfc_word_t p;
		exec(16'h0100);
		exec(16'hb720);
		chk("rpop pc", 16'h0202, pc);
		chk("rpop pop", 16'h0000, 16'(rs_pop));
		chk("rpop top", 16'h0002, top);
		chk("rpop push", 16'h0001, 16'(ps_push));
		exec(16'h8810);
		chk("keep nz pc", 16'h0204, pc);
		chk("keep nz top", 16'h0002, top);
		p = ps_top;
		exec(16'h8010);
		chk("pop nz pc", 16'h0206, pc);
		chk("pop nz top", 16'h0000, top);
		chk("pop nz second", p, second);
		exec(16'h8810);
		chk("keep z pc", 16'h0020, pc);
		chk("keep z pop", 16'h0001, 16'(ps_pop));
		$display("zero test done");
	endtask
	task t_call;
		pfc_word_t li, pv;
		exec(16'hb000, 4'h5);
		li = loop_index;
		pv = pc;
		exec(16'h2a45, 4'h9);
		chk("call pc", 16'h548a, pc);
		chk("call index", pv + 16'h0002, loop_index);
		chk("call ipage", 16'h0005, 16'(index_page_reg));
		chk("push index", li, rs_push_index);
		chk("push", 16'h0001, 16'(rs_push));
		// nested call pushes the saved page, nested return restores it
		exec(16'h0010);
		chk("push page", 16'h0005, 16'(rs_push_page));
		chk("nest ipage", 16'h0009, 16'(index_page_reg));
		exec(16'hb020);
		chk("nest ret pc", 16'h548c, pc);
		chk("nest ret page", 16'h0009, 16'(code_page_reg));
		chk("nest ret ipage", 16'h0005, 16'(index_page_reg));
		exec(16'hb020);
		chk("ret pc", pv + 16'h0002, pc);
		chk("ret page", 16'h0005, 16'(code_page_reg));
		$display("call test done");
	endtask
	task t_blk;
		logic [5:0] eb [4];
		eb = '{6'd2, 6'd3, 6'd1, 6'd0};
		for (int b = 0; b < 4; b++) begin
			exec(16'h97ff);
			exec(16'h91ff);
			chk("edge pc", 16'h07fe, pc);
			exec({5'b10010, b[1:0], 9'h0a5});
			chk("blk pc", {eb[b], 9'h0a5, 1'b0}, pc);
		end
		$display("block test done");
	endtask
	task t_loop;
		pfc_word_t li, ri, sv;
		exec(16'h9600);
		exec(16'h0000);
		for (int k = 2; k > 0; k--) begin
			exec(16'h9800);
			chk("loop index", 16'(k - 1), loop_index);
			chk("loop pc", 16'h0000, pc);
		end
		li = rs_pop_index;
		exec(16'h9800);
		chk("loop end index", li, loop_index);
		chk("loop end pc", 16'h0002, pc);
		// let the stack model apply the loop-end pop before sampling it
		@(posedge core_clk);
		#1;
		ri = rs_pop_index;
		sv = second;
		exec(16'hb700);
		chk("pop read top", li, top);
		chk("pop read index", ri, loop_index);
		chk("pop read rs pop", 16'h0001, 16'(rs_pop));
		chk("pop read push", 16'h0001, 16'(ps_push));
		chk("pop read data", sv, ps_push_data);
		$display("loop test done");
	endtask
	task t_fetch;
		pfc_word_t t, s;
		t = top;
		s = second;
		exec(16'he000);
		chk("fetch rd", 16'h0001, 16'(mem_rd));
		chk("fetch addr", t, mem_addr);
		@(posedge core_clk);
		#1;
		chk("fetch c1 top", s, top);
		chk("fetch c1 second", t ^ 16'h5a5a, second);
		@(posedge core_clk);
		#1;
		chk("fetch top", t ^ 16'h5a5a, top);
		chk("fetch second", s, second);
		$display("fetch test done");
	endtask
	initial begin
		rst_b = 1'b0;
		instr = 16'h0000;
		instr_valid = 1'b0;
		code_page_wr = 1'b0;
		code_page_wdata = 4'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		t_zero();
		t_call();
		t_blk();
		t_loop();
		t_fetch();
		complete_run();
	end
endmodule
